// File: aad_acc_datapath.sv
// aad_acc_datapath: accumulator add/and datapath with AHB-Lite register access
// assumes: one AHB-Lite master, single word transfers, synchronous reset
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module aad_acc_datapath
    import aad_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    ////////////////////////////////////////////////////////////////////////
    // bus address phase capture
    logic phValid_reg, phValid_next;
    logic phWrite_reg, phWrite_next;
    logic [7:0] phAddr_reg, phAddr_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic memHeld_reg, memHeld_next;

    ////////////////////////////////////////////////////////////////////////
    // datapath state
    aad_state_e state_reg, state_next;
    aad_op_e op_reg, op_next;
    logic [MEM_AW-1:0] opAddr_reg, opAddr_next;
    logic [7:0] imm_reg, imm_next;
    logic [7:0] acc_reg, acc_next;
    logic carryFlag_reg, carryFlag_next;
    logic half_carry_flag_reg, half_carry_flag_next;
    logic zeroFlag_reg, zeroFlag_next;
    logic overflow_flag_reg, overflow_flag_next;

    // memory ports
    logic memWrEn;
    logic [MEM_AW-1:0] memWrAddr;
    logic [7:0] memWrData;
    logic [MEM_AW-1:0] memRdAddr;
    logic [7:0] memRdData;

    aad_data_mem u_mem (
        .clk_sys(clk_sys),
        .wrEn(memWrEn),
        .wrAddr(memWrAddr),
        .wrData(memWrData),
        .rdAddr(memRdAddr),
        .rdData(memRdData)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode of current data phase
    logic wrPhase, rdPhase, isMem, busy;
    logic [MEM_AW-1:0] busMemAddr;
    logic [8:0] sumFull;
    logic [4:0] sumLow;
    logic [7:0] andMem;
    logic [7:0] andImm;

    always_comb begin
        busy = (state_reg != ST_IDLE);
        wrPhase = phValid_reg && phWrite_reg;
        rdPhase = phValid_reg && !phWrite_reg;
        isMem = (phAddr_reg >= ADDR_MEM_BASE) && (phAddr_reg < ADDR_MEM_BASE + 8'(MEM_DEPTH * 4));
        busMemAddr = MEM_AW'((phAddr_reg - ADDR_MEM_BASE) >> 2);
        sumFull = {1'b0, acc_reg} + {1'b0, memRdData};
        sumLow = {1'b0, acc_reg[3:0]} + {1'b0, memRdData[3:0]};
        andMem = acc_reg & memRdData;
        andImm = acc_reg & imm_reg;
    end

    // the memory read port is registered: a memory read waits one cycle for the byte,
    // and any memory access waits out a running op
    always_comb begin
        hreadyout = !(phValid_reg && isMem && (busy || (!phWrite_reg && !memHeld_reg)));
        hresp = 1'b0;
        hrdata = memHeld_reg ? {24'h00_0000, memRdData} : hrdata_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus next state
    always_comb begin
        phValid_next = phValid_reg;
        phWrite_next = phWrite_reg;
        phAddr_next = phAddr_reg;
        hrdata_next = 32'h0000_0000;
        memHeld_next = rdPhase && isMem && !busy && !memHeld_reg;
        if (hreadyout) begin
            phValid_next = hsel && htrans[1] && hready;
            phWrite_next = hwrite;
            phAddr_next = haddr[7:0];
            // register reads see the values as they stand once this cycle's write has landed
            if (hsel && htrans[1] && hready && !hwrite) begin
                unique case (haddr[7:0])
                    ADDR_CTRL: hrdata_next = {24'h00_0000, imm_next};
                    ADDR_ACC: hrdata_next = {24'h00_0000, acc_next};
                    ADDR_STATUS: hrdata_next = {27'h000_0000, state_next != ST_IDLE, overflow_flag_next,
                                                zeroFlag_next, half_carry_flag_next, carryFlag_next};
                    default: hrdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // datapath next state
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        opAddr_next = opAddr_reg;
        imm_next = imm_reg;
        acc_next = acc_reg;
        carryFlag_next = carryFlag_reg;
        half_carry_flag_next = half_carry_flag_reg;
        zeroFlag_next = zeroFlag_reg;
        overflow_flag_next = overflow_flag_reg;
        memWrEn = 1'b0;
        memWrAddr = busMemAddr;
        memWrData = hwdata[7:0];
        memRdAddr = busy ? opAddr_reg : busMemAddr;
        unique case (state_reg)
            ST_IDLE: begin
                if (wrPhase && isMem) begin
                    memWrEn = 1'b1;
                end else if (wrPhase && phAddr_reg == ADDR_ACC) begin
                    acc_next = hwdata[7:0];
                end else if (wrPhase && phAddr_reg == ADDR_STATUS) begin
                    carryFlag_next = hwdata[ST_CARRY];
                    half_carry_flag_next = hwdata[ST_HALF];
                    zeroFlag_next = hwdata[ST_ZERO];
                    overflow_flag_next = hwdata[ST_OVF];
                end else if (wrPhase && phAddr_reg == ADDR_CTRL) begin
                    op_next = aad_op_e'(hwdata[CTRL_OP_LSB +: 2]);
                    opAddr_next = hwdata[CTRL_ADDR_LSB +: MEM_AW];
                    imm_next = hwdata[CTRL_IMM_LSB +: 8];
                    if (hwdata[CTRL_GO_BIT]) begin
                        state_next = ST_READ;
                    end
                end
            end
            ST_READ: begin
                state_next = ST_EXEC;
            end
            ST_EXEC: begin
                state_next = ST_IDLE;
                memWrAddr = opAddr_reg;
                unique case (op_reg)
                    OP_ADD_ACC_INTO_MEMORY: begin
                        memWrEn = 1'b1;
                        memWrData = sumFull[7:0];
                        carryFlag_next = sumFull[8];
                        half_carry_flag_next = sumLow[4];
                        overflow_flag_next = (acc_reg[7] == memRdData[7]) && (sumFull[7] != acc_reg[7]);
                        zeroFlag_next = (sumFull[7:0] == 8'h00);
                    end
                    OP_AND_MEM_TO_ACC: begin
                        acc_next = andMem;
                        zeroFlag_next = (andMem == 8'h00);
                    end
                    OP_AND_IMM_TO_ACC: begin
                        acc_next = andImm;
                        zeroFlag_next = (andImm == 8'h00);
                    end
                    OP_AND_ACC_INTO_MEMORY: begin
                        memWrEn = 1'b1;
                        memWrData = andMem;
                        zeroFlag_next = (andMem == 8'h00);
                    end
                endcase
            end
            default: state_next = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            phValid_reg <= 1'b0;
            phWrite_reg <= 1'b0;
            phAddr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
            memHeld_reg <= 1'b0;
            state_reg <= ST_IDLE;
            op_reg <= OP_ADD_ACC_INTO_MEMORY;
            opAddr_reg <= '0;
            imm_reg <= 8'h00;
            acc_reg <= ACC_RESET;
            {overflow_flag_reg, zeroFlag_reg, half_carry_flag_reg, carryFlag_reg} <= FLAGS_RESET;
        end else begin
            phValid_reg <= phValid_next;
            phWrite_reg <= phWrite_next;
            phAddr_reg <= phAddr_next;
            hrdata_reg <= hrdata_next;
            memHeld_reg <= memHeld_next;
            state_reg <= state_next;
            op_reg <= op_next;
            opAddr_reg <= opAddr_next;
            imm_reg <= imm_next;
            acc_reg <= acc_next;
            carryFlag_reg <= carryFlag_next;
            half_carry_flag_reg <= half_carry_flag_next;
            zeroFlag_reg <= zeroFlag_next;
            overflow_flag_reg <= overflow_flag_next;
        end
    end
endmodule
`default_nettype wire

// File: aad_pkg.sv
// aad_pkg: constants shared by the accumulator datapath and its bus slave
// assumes: 32-bit AHB-Lite data, one aligned word per register
package aad_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ACC = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MEM_BASE = 8'h40;
    // control word fields
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_ADDR_LSB = 4;
    localparam int CTRL_IMM_LSB = 8;
    localparam int CTRL_GO_BIT = 16;
    // status word field positions
    localparam int ST_CARRY = 0;
    localparam int ST_HALF = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_OVF = 3;
    localparam int ST_BUSY = 4;
    // data memory geometry and reset values
    localparam int MEM_AW = 4;
    localparam int MEM_DEPTH = 16;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    // operation codes
    typedef enum logic [1:0] {
        OP_ADD_ACC_INTO_MEMORY = 2'h0,
        OP_AND_MEM_TO_ACC = 2'h1,
        OP_AND_IMM_TO_ACC = 2'h2,
        OP_AND_ACC_INTO_MEMORY = 2'h3
    } aad_op_e;
    // execution sequence; each step changes one bit except the return from ST_EXEC to ST_IDLE
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_EXEC = 2'b11
    } aad_state_e;
endpackage

// File: aad_data_mem.sv
// aad_data_mem: small byte-wide data memory, registered read data
// assumes: single clock, one write port and one read port
`timescale 1ns/1ps
`default_nettype none
module aad_data_mem
    import aad_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // write port
    input wire logic wrEn,
    input wire logic [MEM_AW-1:0] wrAddr,
    input wire logic [7:0] wrData,
    // read port
    input wire logic [MEM_AW-1:0] rdAddr,
    output logic [7:0] rdData
);
    logic [7:0] memArray [MEM_DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            memArray[wrAddr] <= wrData;
        end
        rdData <= memArray[rdAddr];
    end
endmodule
`default_nettype wire

// File: aad_acc_datapath_sva.sv
// bus-level checks for the accumulator datapath
// assumes: bound to the datapath top, single AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module aad_acc_datapath_sva
    import aad_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic tk;
    assign tk = hsel && htrans[1] && hready;
    sequence mem_answer_s;
        !hreadyout ##[1:3] hreadyout;
    endsequence
    ////////////////////////////////////////////////////////////////
    okay_resp_a: assert property (hresp == 1'b0) else $error("non-okay response");
    rst_idle_a: assert property (disable iff (1'b0) sys_rst |=> hreadyout && hrdata == 32'h0)
        else $error("bus not idle after reset");
    reg_nowait_a: assert property (tk && haddr[7:6] == 2'h0 |=> hreadyout) else $error("register wait");
    mem_wait_a: assert property (tk && !hwrite && haddr[7:6] == 2'h1 |=> mem_answer_s)
        else $error("memory read timing");
    hole_zero_a: assert property (tk && !hwrite && haddr[7:0] inside {[8'h0C:8'h3C]} |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    acc_high_a: assert property (tk && !hwrite && haddr[7:0] == ADDR_ACC |=> hrdata[31:8] == 24'h0)
        else $error("acc upper bits set");
    status_high_a: assert property (tk && !hwrite && haddr[7:0] == ADDR_STATUS |=> hrdata[31:5] == 27'h0)
        else $error("status upper bits set");
    ctrl_high_a: assert property (tk && !hwrite && haddr[7:0] == ADDR_CTRL |=> hrdata[31:8] == 24'h0)
        else $error("ctrl upper bits set");
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the accumulator datapath
// assumes: the bench is the only bus master
`timescale 1ns/1ps
`default_nettype none
module testbench
    import aad_pkg::*;
;
    logic clk_sys = 0, sys_rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    int fails = 0, checks_done = 0, seed = 57097;
    aad_acc_datapath dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));
    initial forever #10 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one single transfer; answers are taken at the edge that sees hready high
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(negedge clk_sys); while (hreadyout !== 1'b1);
        @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= d;
        do @(negedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
        @(posedge clk_sys);
    endtask
    function automatic logic [19:0] model(logic [1:0] op, logic [7:0] a, logic [7:0] m, logic [7:0] i,
        logic [3:0] f);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r, na, nm;
        s = a + m;
        h = a[3:0] + m[3:0];
        na = a;
        nm = m;
        case (op)
            2'h0: begin
                r = s[7:0];
                nm = r;
                f[0] = s[8];
                f[1] = h[4];
                f[3] = (a[7] == m[7]) && (r[7] != a[7]);
            end
            2'h1: begin r = a & m; na = r; end
            2'h2: begin r = a & i; na = r; end
            default: begin r = a & m; nm = r; end
        endcase
        f[2] = (r == 8'h00);
        return {na, nm, f};
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [19:0] e;
        logic [7:0] a, m, i, ma;
        logic [3:0] f, ad;
        logic [1:0] op;
        int k;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        bus(ADDR_ACC, 1'b0, 32'h0, r); check("acc reset", r, {24'h0, ACC_RESET});
        bus(ADDR_STATUS, 1'b0, 32'h0, r); check("status reset", r, {28'h0, FLAGS_RESET});
        bus(8'h0C, 1'b1, 32'hFFFF_FFFF, r);
        bus(8'h0C, 1'b0, 32'h0, r); check("unmapped", r, 32'h0);
        for (int n = 0; n < 48; n++) begin
            a = 8'($random(seed));
            m = 8'($random(seed));
            i = 8'($random(seed));
            f = 4'($random(seed));
            ad = 4'($random(seed));
            op = n[1:0];
            if (n < 4) begin a = 8'h7F; m = 8'h01; end
            else if (n < 8) begin a = 8'hFF; m = 8'h01; i = 8'h00; end
            else if (n < 12) begin a = 8'h0F; m = 8'hF0; i = 8'hF0; end
            ma = 8'h40 + {2'h0, ad, 2'h0};
            bus(ADDR_ACC, 1'b1, {24'h0, a}, r);
            bus(ma, 1'b1, {24'h0, m}, r);
            bus(ADDR_STATUS, 1'b1, {28'h0, f}, r);
            bus(ADDR_CTRL, 1'b1, {15'h0, 1'b1, i, ad, 2'h0, op}, r);
            // an acc write whose data phase falls in the op's last cycle is dropped
            if (n[2]) bus(ADDR_ACC, 1'b1, {24'h0, ~a}, r);
            k = 0;
            do begin
                bus(ADDR_STATUS, 1'b0, 32'h0, r);
                if (k == 0) check("busy", {31'h0, r[ST_BUSY]}, {31'h0, ~n[2]});
                k++;
            end while (r[ST_BUSY] !== 1'b0 && k < 10);
            e = model(op, a, m, i, f);
            check("flags", r, {28'h0, e[3:0]});
            bus(ADDR_ACC, 1'b0, 32'h0, r); check("acc", r, {24'h0, e[19:12]});
            bus(ma, 1'b0, 32'h0, r); check("memory", r, {24'h0, e[11:4]});
            bus(ADDR_CTRL, 1'b0, 32'h0, r); check("ctrl imm", r, {24'h0, i});
        end
        // reset in mid-run must bring acc and flags back
        bus(ADDR_ACC, 1'b1, 32'h0000_00A5, r);
        bus(ADDR_STATUS, 1'b1, 32'h0000_000F, r);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        bus(ADDR_ACC, 1'b0, 32'h0, r); check("acc after reset", r, {24'h0, ACC_RESET});
        bus(ADDR_STATUS, 1'b0, 32'h0, r); check("status after reset", r, {28'h0, FLAGS_RESET});
        finish_test();
    end
    // some 940 cycles are needed; the limit allows about ten times that
    initial begin
        #200000;
        fails++;
        finish_test();
    end
endmodule
bind aad_acc_datapath aad_acc_datapath_sva chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));
`default_nettype wire
